// [hdl/isnu_top.sv]
// subtract-from and negate datapath with exception and condition bits
`timescale 1ns/1ns
`default_nettype none
module isnu_top
(
  // clock and reset
  input  wire logic                CLK_IN,
  input  wire logic                RESETN_IN,
  // instruction issue
  input  wire logic                VALID_IN,
  input  wire isnu_pkg::isnu_req_s REQ_IN,
  // software load of exception bits (move-to path)
  input  wire logic                EXC_WE_IN,
  input  wire isnu_pkg::isnu_exc_s EXC_IN,
  // result
  output logic                     DONE_OUT,
  output logic [31:0]              RESULT_OUT,
  output logic                     CF_WE_OUT,
  output logic [3:0]               CF_OUT,
  output var isnu_pkg::isnu_exc_s  EXC_OUT
);

  // ==========================================================
  // state
  typedef struct packed {
    logic                done;
    logic [31:0]         result;
    logic                cf_we;
    logic [3:0]          cf;
    isnu_pkg::isnu_exc_s exc;
  } isnu_state_s;

  isnu_state_s st;
  isnu_state_s next_st;

  // ==========================================================
  // operand selection
  logic [31:0] opa;
  logic [31:0] opb;
  logic        cin;
  logic        writes_carry;
  logic        legal;
  logic [31:0] imm_ext;
  logic [31:0] sum;
  logic        carry;
  logic        ovf;

  assign imm_ext = {{16{REQ_IN.signed_immediate[15]}},
                    REQ_IN.signed_immediate};

  always_comb
  begin
    opa          = ~REQ_IN.first_src_reg;
    opb          = REQ_IN.second_src_reg;
    cin          = 1'b1;
    writes_carry = 1'b0;
    legal        = 1'b1;
    // extended forms take the stored carry, not a same-cycle load
    case (REQ_IN.op)
      isnu_pkg::ISNU_OP_SUB:
      begin
        cin = 1'b1;
      end
      isnu_pkg::ISNU_OP_SUB_CARRY:
      begin
        writes_carry = 1'b1;
      end
      isnu_pkg::ISNU_OP_SUB_IMM:
      begin
        opb          = imm_ext;
        writes_carry = 1'b1;
      end
      isnu_pkg::ISNU_OP_SUB_EXT:
      begin
        cin          = st.exc.carry_bit;
        writes_carry = 1'b1;
      end
      isnu_pkg::ISNU_OP_SUB_M1:
      begin
        opb          = isnu_pkg::ALL_ONES;
        cin          = st.exc.carry_bit;
        writes_carry = 1'b1;
      end
      isnu_pkg::ISNU_OP_SUB_ZEXT:
      begin
        opb          = 32'h0000_0000;
        cin          = st.exc.carry_bit;
        writes_carry = 1'b1;
      end
      isnu_pkg::ISNU_OP_NEGATE:
      begin
        opb = 32'h0000_0000;
      end
      default:
      begin
        legal = 1'b0;
      end
    endcase
  end

  isnu_adder
  #(
    .WIDTH (isnu_pkg::DATA_W)
  )
  u_adder
  (
    .a_in      (opa),
    .b_in      (opb),
    .cin_in    (cin),
    .sum_out   (sum),
    .carry_out (carry),
    .ovf_out   (ovf)
  );

  // ==========================================================
  // next state
  logic ovf_on;
  logic rec_en;
  logic next_so;

  always_comb
  begin
    next_st       = st;
    next_st.done  = 1'b0;
    next_st.cf_we = 1'b0;
    // immediate form has no overflow or record variant
    ovf_on = legal && REQ_IN.ovf_en
             && (REQ_IN.op != isnu_pkg::ISNU_OP_SUB_IMM);
    rec_en = legal && REQ_IN.rec
             && (REQ_IN.op != isnu_pkg::ISNU_OP_SUB_IMM);
    // load first, so a same-cycle instruction wins: sticky set beats clear
    if (EXC_WE_IN)
    begin
      next_st.exc = EXC_IN;
    end
    next_so = next_st.exc.summary_ovf;
    if (VALID_IN && legal)
    begin
      next_st.done   = 1'b1;
      next_st.result = sum;
      if (writes_carry)
      begin
        next_st.exc.carry_bit = carry;
      end
      if (ovf_on)
      begin
        next_st.exc.overflow_bit = ovf;
        next_so                  = next_so | ovf;
        next_st.exc.summary_ovf  = next_so;
      end
      if (rec_en)
      begin
        next_st.cf_we = 1'b1;
        next_st.cf[isnu_pkg::CF_NEG]  = sum[31];
        next_st.cf[isnu_pkg::CF_POS]  = ~sum[31] && (sum != '0);
        next_st.cf[isnu_pkg::CF_ZERO] = (sum == '0);
        next_st.cf[isnu_pkg::CF_SO]   = next_so;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      st.done   <= 1'b0;
      st.result <= isnu_pkg::RST_RESULT;
      st.cf_we  <= 1'b0;
      st.cf     <= isnu_pkg::RST_CF;
      st.exc    <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign DONE_OUT   = st.done;
  assign RESULT_OUT = st.result;
  assign CF_WE_OUT  = st.cf_we;
  assign CF_OUT     = st.cf;
  assign EXC_OUT    = st.exc;

  // ==========================================================
  // checks
  a_sub_result: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    VALID_IN && REQ_IN.op == isnu_pkg::ISNU_OP_SUB && !EXC_WE_IN
    |=> RESULT_OUT == $past(REQ_IN.second_src_reg)
                      - $past(REQ_IN.first_src_reg))
    else $error("subtract-from result wrong");

  a_plain_no_flags: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    VALID_IN && REQ_IN.op == isnu_pkg::ISNU_OP_SUB && !REQ_IN.rec
    && !REQ_IN.ovf_en && !EXC_WE_IN
    |=> !CF_WE_OUT && $stable(EXC_OUT))
    else $error("plain form changed flags");

  a_neg_keeps_carry: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    VALID_IN && REQ_IN.op == isnu_pkg::ISNU_OP_NEGATE && !EXC_WE_IN
    |=> EXC_OUT.carry_bit == $past(EXC_OUT.carry_bit))
    else $error("negate altered carry");

  a_carry_update: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    VALID_IN && REQ_IN.op == isnu_pkg::ISNU_OP_SUB_CARRY
    |=> EXC_OUT.carry_bit ==
        ({1'b0, $past(REQ_IN.second_src_reg)}
         >= {1'b0, $past(REQ_IN.first_src_reg)}))
    else $error("carrying form carry wrong");

  a_ext_result: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    VALID_IN && REQ_IN.op == isnu_pkg::ISNU_OP_SUB_ZEXT
    |=> RESULT_OUT == ~$past(REQ_IN.first_src_reg)
                      + {31'h0, $past(EXC_OUT.carry_bit)})
    else $error("zero-extended result wrong");

  a_imm_result: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    VALID_IN && REQ_IN.op == isnu_pkg::ISNU_OP_SUB_IMM
    |=> RESULT_OUT == 32'($signed($past(REQ_IN.signed_immediate)))
                      - $past(REQ_IN.first_src_reg) && !CF_WE_OUT)
    else $error("immediate result wrong");

  a_so_sticky: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    EXC_OUT.summary_ovf && !EXC_WE_IN |=> EXC_OUT.summary_ovf)
    else $error("summary overflow lost");

  a_cf_matches: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    CF_WE_OUT |-> CF_OUT[isnu_pkg::CF_ZERO] == (RESULT_OUT == '0)
                  && CF_OUT[isnu_pkg::CF_NEG] == RESULT_OUT[31]
                  && CF_OUT[isnu_pkg::CF_SO] == EXC_OUT.summary_ovf)
    else $error("condition field inconsistent");

  a_neg_ovf: assert property (
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    VALID_IN && REQ_IN.op == isnu_pkg::ISNU_OP_NEGATE && REQ_IN.ovf_en
    && !EXC_WE_IN
    |=> EXC_OUT.overflow_bit == ($past(REQ_IN.first_src_reg)
                                 == 32'h8000_0000))
    else $error("negate overflow wrong");

endmodule
`default_nettype wire

// [hdl/isnu_pkg.sv]
// package: operation codes, field layouts and reset values
package isnu_pkg;

  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IMM_W    = 16;
  localparam int unsigned OP_W     = 3;
  localparam int unsigned CF_W     = 4;

  // condition field bit positions: lt, gt, eq, summary copy
  localparam int unsigned CF_NEG   = 3;
  localparam int unsigned CF_POS   = 2;
  localparam int unsigned CF_ZERO  = 1;
  localparam int unsigned CF_SO    = 0;

  localparam logic [31:0] RST_RESULT = 32'h0000_0000;
  localparam logic [3:0]  RST_CF     = 4'h0;
  localparam logic        RST_BIT    = 1'b0;
  localparam logic [31:0] ALL_ONES   = 32'hFFFF_FFFF;
  localparam logic [31:0] ONE_WORD   = 32'h0000_0001;

  typedef enum logic [2:0] {
    ISNU_OP_SUB       = 3'b000,
    ISNU_OP_SUB_CARRY = 3'b001,
    ISNU_OP_SUB_IMM   = 3'b010,
    ISNU_OP_SUB_EXT   = 3'b011,
    ISNU_OP_SUB_M1    = 3'b100,
    ISNU_OP_SUB_ZEXT  = 3'b101,
    ISNU_OP_NEGATE    = 3'b110,
    ISNU_OP_IDLE      = 3'b111
  } isnu_op_e;

  // one issued instruction
  typedef struct packed {
    isnu_op_e    op;
    logic        ovf_en;
    logic        rec;
    logic [31:0] first_src_reg;
    logic [31:0] second_src_reg;
    logic [15:0] signed_immediate;
  } isnu_req_s;

  // fixed-point exception register bits kept by this unit
  typedef struct packed {
    logic summary_ovf;
    logic overflow_bit;
    logic carry_bit;
  } isnu_exc_s;

  // adder outcome
  typedef struct packed {
    logic [31:0] sum;
    logic        carry;
    logic        ovf;
  } isnu_add_s;

endpackage

// [hdl/isnu_adder.sv]
// three-input 32-bit adder with carry and signed overflow
`timescale 1ns/1ns
`default_nettype none
module isnu_adder
#(
  parameter int unsigned WIDTH = 32
)
(
  // operands
  input  wire logic [WIDTH-1:0] a_in,
  input  wire logic [WIDTH-1:0] b_in,
  input  wire logic             cin_in,
  // outcome
  output logic      [WIDTH-1:0] sum_out,
  output logic                  carry_out,
  output logic                  ovf_out
);

  logic [WIDTH:0] full;

  always_comb
  begin
    full      = {1'b0, a_in} + {1'b0, b_in} + {{WIDTH{1'b0}}, cin_in};
    sum_out   = full[WIDTH-1:0];
    carry_out = full[WIDTH];
    // signed overflow: like-signed operands, sum sign differs
    ovf_out   = (a_in[WIDTH-1] == b_in[WIDTH-1])
              && (full[WIDTH-1] != a_in[WIDTH-1]);
  end

endmodule
`default_nettype wire

// [sim/isnu_regfile_model.sv]
// partner model: register pair taking the unit's write-backs
`timescale 1ns/1ns
`default_nettype none
module isnu_regfile_model
(
  // issue side
  input  wire logic        clk_in,
  input  wire logic        valid_in,
  input  wire logic        dest_in,
  // write-back side
  input  wire logic        done_in,
  input  wire logic [31:0] result_in,
  output logic      [63:0] pair_out
);
  logic dest_q;
  // destination travels with the instruction, so back-to-back works
  always_ff @(posedge clk_in)
  begin
    if (valid_in)
      dest_q <= dest_in;
    if (done_in && dest_q)
      pair_out[63:32] <= result_in;
    else if (done_in)
      pair_out[31:0] <= result_in;
  end
endmodule
`default_nettype wire

// [sim/isnu_top_tb_top.sv]
// testbench: random and corner instructions against a bench model
`timescale 1ns/1ns
`default_nettype none
module isnu_top_tb_top;
  logic                clk, rstn, valid, xwe, dest, done, cfwe;
  logic                m_done, m_cfwe;
  logic [31:0]         result, lfsr, m_res;
  logic [3:0]          cf, m_cf;
  logic [63:0]         pair, a64, b64;
  isnu_pkg::isnu_req_s req;
  isnu_pkg::isnu_exc_s xin, xout, mx;
  int                  errors, n_compared;

  isnu_top i_isnu_top (.CLK_IN(clk), .RESETN_IN(rstn), .VALID_IN(valid),
    .REQ_IN(req), .EXC_WE_IN(xwe), .EXC_IN(xin), .DONE_OUT(done),
    .RESULT_OUT(result), .CF_WE_OUT(cfwe), .CF_OUT(cf), .EXC_OUT(xout));
  isnu_regfile_model i_isnu_regfile_model (.clk_in(clk), .valid_in(valid),
    .dest_in(dest), .done_in(done), .result_in(result), .pair_out(pair));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic isnu_pkg::isnu_req_s mk(input logic [2:0] op,
    input logic [1:0] fl, input logic [31:0] a, input logic [31:0] b);
    isnu_pkg::isnu_req_s r;
    r.op = isnu_pkg::isnu_op_e'(op);
    {r.ovf_en, r.rec} = fl;
    r.first_src_reg = a;
    r.second_src_reg = b;
    r.signed_immediate = b[15:0];
    return r;
  endfunction

  // operand zero or the most negative value hits the overflow corners
  function automatic logic [31:0] opnd();
    logic [31:0] v;
    v = rnd();
    return (v[1:0] == 2'd0) ? {v[2], 31'h0000_0000} : rnd();
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // load path first, then the instruction's own updates; the carry-in
  // of the extended forms is the bit stored before a same-cycle load
  function automatic void predict(input isnu_pkg::isnu_req_s r,
    input logic v, input logic w, input isnu_pkg::isnu_exc_s xl);
    logic [31:0] na, y;
    logic [32:0] s;
    logic        ov, fl, ci;
    longint      lv;
    m_done = v && (r.op != isnu_pkg::ISNU_OP_IDLE);
    m_cfwe = 1'b0;
    ci = mx.carry_bit;
    if (w)
      mx = xl;
    if (!m_done)
      return;
    na = ~r.first_src_reg;
    case (r.op)
      isnu_pkg::ISNU_OP_SUB_IMM: y = {{16{r.signed_immediate[15]}},
        r.signed_immediate};
      isnu_pkg::ISNU_OP_SUB_M1: y = 32'hFFFF_FFFF;
      isnu_pkg::ISNU_OP_SUB_ZEXT, isnu_pkg::ISNU_OP_NEGATE: y = 32'h0000_0000;
      default: y = r.second_src_reg;
    endcase
    if (!(r.op inside {isnu_pkg::ISNU_OP_SUB_EXT, isnu_pkg::ISNU_OP_SUB_M1,
      isnu_pkg::ISNU_OP_SUB_ZEXT}))
      ci = 1'b1;
    s = {1'b0, na} + {1'b0, y} + {32'h0000_0000, ci};
    // exact signed sum: overflow when the 32-bit result differs from it
    lv = longint'($signed(na)) + longint'($signed(y)) + longint'(ci);
    ov = lv != longint'($signed(s[31:0]));
    m_res = s[31:0];
    if (r.op inside {[isnu_pkg::ISNU_OP_SUB_CARRY:
      isnu_pkg::ISNU_OP_SUB_ZEXT]})
      mx.carry_bit = s[32];
    fl = r.op != isnu_pkg::ISNU_OP_SUB_IMM;
    if (fl && r.ovf_en)
    begin
      mx.overflow_bit = ov;
      mx.summary_ovf = mx.summary_ovf | ov;
    end
    if (fl && r.rec)
    begin
      m_cfwe = 1'b1;
      m_cf = {s[31], !s[31] && (s[31:0] != 0), s[31:0] == 0, mx.summary_ovf};
    end
  endfunction

  task automatic step(input isnu_pkg::isnu_req_s r, input logic v,
    input logic w);
    isnu_pkg::isnu_exc_s xl;
    logic [31:0]         t;
    t = rnd();
    xl = t[2:0];
    @(posedge clk);
    valid <= v;
    req <= r;
    xwe <= w;
    xin <= xl;
    dest <= r.op == isnu_pkg::ISNU_OP_SUB_EXT;
    #1;
    check(done, m_done);
    check(result, m_res);
    check(cfwe, m_cfwe);
    check(cf, m_cf);
    check(xout, mx);
    predict(r, v, w, xl);
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #40000;
    errors++;
    give_verdict();
  end

  initial
  begin
    {rstn, valid, xwe, dest, m_done, m_cfwe} = 6'h00;
    req = '0;
    xin = '0;
    mx = '0;
    m_res = 32'h0000_0000;
    m_cf = 4'h0;
    lfsr = 32'h0000_52DD;
    errors = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // every op code, including the refused one, with every flag pair
    for (int i = 0; i < 96; i++)
      step(mk(3'(i >> 2), 2'(i), opnd(), opnd()), 1'b1, 1'b0);
    $display("test all codes done");
    // 64-bit subtract chained across the carry
    for (int k = 0; k < 20; k++)
    begin
      a64 = {opnd(), opnd()};
      b64 = {opnd(), opnd()};
      step(mk(3'd1, 2'(k), a64[31:0], b64[31:0]), 1'b1, 1'b0);
      step(mk(3'd3, 2'(k), a64[63:32], b64[63:32]), 1'b1, 1'b0);
      step(mk(3'd7, 2'd0, 32'h0000_0000, 32'h0000_0000), 1'b0, 1'b0);
      step(mk(3'd7, 2'd0, 32'h0000_0000, 32'h0000_0000), 1'b0, 1'b0);
      check(pair[31:0], b64[31:0] - a64[31:0]);
      check(pair[63:32], 32'((b64 - a64) >> 32));
    end
    $display("test wide chain done");
    // random mix with idle cycles and load-path collisions
    for (int n = 0; n < 1500; n++)
      step(mk(3'(rnd()), 2'(rnd()), opnd(), opnd()), rnd() > 32'h2000_0000,
        rnd() < 32'h2000_0000);
    $display("test random mix done");
    give_verdict();
  end
endmodule
`default_nettype wire
